// [design/lsio_pkg.sv]
// Package for the load status and input object bank
package lsio_pkg;

  // Object indices
  localparam logic [15:0] IDX_QUES = 16'h200B;
  localparam logic [15:0] IDX_STAT = 16'h200D;
  localparam logic [15:0] IDX_INPUT = 16'h2011;

  // Questionable word bit positions
  localparam int Q_VPROT = 0;
  localparam int Q_CTRIP = 1;
  localparam int Q_VTRIP = 2;
  localparam int Q_PTRIP = 3;
  localparam int Q_CPROT = 4;
  localparam int Q_TPROT = 5;
  localparam int Q_SENSE = 6;
  localparam int Q_MODE_I = 7;
  localparam int Q_MODE_V = 8;
  localparam int Q_MODE_R = 9;
  localparam int Q_CP = 10;
  localparam int Q_SOFT = 11;
  localparam int Q_HARD = 12;
  localparam int Q_INTLK = 13;
  localparam int Q_PWR_LOSS = 14;
  localparam int Q_IOF = 15;

  // Status word 0 bit positions
  localparam int S0_STANDBY = 0;
  localparam int S0_LIVE = 1;
  localparam int S0_CTRIP = 4;
  localparam int S0_VTRIP = 5;
  localparam int S0_PTRIP = 6;
  localparam int S0_SENSE = 7;
  localparam int S0_UVTRIP = 8;
  localparam int S0_START_FAIL = 12;
  localparam int S0_START_PEND = 13;
  localparam int S0_TERM_I = 16;
  localparam int S0_TERM_V = 17;
  localparam int S0_LIN_HOT = 18;
  localparam int S0_INTLK = 20;
  localparam int S0_DIODE_HOT = 23;
  localparam int S0_LINEFLT = 26;
  localparam int S0_RES_HOT = 27;
  localparam int S0_REG_LOST = 29;

  // Status word 1 bit positions
  localparam int S1_PHASE = 0;
  localparam int S1_FUSE = 1;
  localparam int S1_FAN = 2;
  localparam int S1_TMOD = 4;
  localparam int S1_TFILT = 5;
  localparam int S1_TCAP = 6;
  localparam int S1_TXFMR = 7;

  // Bits that may be nonzero; available slots read zero
  localparam logic [31:0] S0_MASK = 32'h7FDFFFF3;
  localparam logic [31:0] S1_MASK = 32'h000300F7;
  localparam logic [31:0] Q_MASK = 32'h0000FFFF;

  // Reset value of the input enable
  localparam logic INPUT_EN_RST = 1'b0;

  // Regulation mode one-hot
  typedef enum logic [3:0] {
    MODE_CUR = 4'h1,
    MODE_VOLT = 4'h2,
    MODE_RES = 4'h4,
    MODE_CP = 4'h8
  } lsio_mode_type;

  // Object access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] index;
    logic [31:0] wdata;
  } lsio_req_type;

  // Object access answer
  typedef struct packed {
    logic valid;
    logic err;
    logic [63:0] rdata;
  } lsio_rsp_type;

endpackage : lsio_pkg

// [design/lsio_bank.sv]
// Status object bank and input enable object of the electronic load
// Function
// - Questionable word readable, live, not held
// - Questionable read has no side effect
// - Hard fault bits 0, 4, 5, 6
// - Soft trip bits 1, 2, 3
// - Bits 7 to 10 regulation mode
// - Bit 11 ORs soft faults
// - Bit 12 ORs hard faults
// - Bits 13-15 interlock, power loss, io fault
// - Operation status readable, live, unaltered by read
// - Questionable derived from status flags and mode, temperature, power loss inputs, fixed layout
// - Word 0 bits 0, 1 standby, active
// - Word 0 bits 4-8 trips, sense, undervoltage
// - Word 0 bits 16, 17 terminal ratings
// - Word 0 bits 18, 23, 27 module heat
// - Word 0 bits 12, 13 target start
// - Word 0 bit 29 regulation lost
// - Word 1 phase, fuse, fan, temperatures
// - Input enable object; disabled means high impedance
module lsio_bank
  import lsio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Object access from the fieldbus slave
  input wire lsio_req_type req,
  output lsio_rsp_type rsp,
  // Raw conditions from the load (asynchronous)
  input wire logic [31:0] status0_raw,
  input wire logic [31:0] status1_raw,
  input wire logic [3:0] reg_mode_raw,
  input wire logic temp_protect_raw,
  input wire logic input_power_loss_raw,
  // Load input control
  output logic load_input_enable,
  output logic input_high_z
);

  logic [31:0] s0_meta_reg;
  logic [31:0] s0_sync_reg;
  logic [31:0] s1_meta_reg;
  logic [31:0] s1_sync_reg;
  logic [5:0] misc_meta_reg;
  logic [5:0] misc_sync_reg;
  logic [31:0] operation_status_word0;
  logic [31:0] operation_status_word1;
  logic [31:0] questionable_fault_word;
  logic any_soft_fault;
  logic any_hard_fault;
  logic [15:0] q_bits;
  logic enable_reg;
  logic [63:0] rdata_next;
  logic err_next;

  // Two-stage synchronisers for all raw conditions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s0_meta_reg <= 32'h00000000;
      s0_sync_reg <= 32'h00000000;
      s1_meta_reg <= 32'h00000000;
      s1_sync_reg <= 32'h00000000;
      misc_meta_reg <= 6'h00;
      misc_sync_reg <= 6'h00;
    end else begin
      s0_meta_reg <= status0_raw;
      s0_sync_reg <= s0_meta_reg;
      s1_meta_reg <= status1_raw;
      s1_sync_reg <= s1_meta_reg;
      misc_meta_reg <= {input_power_loss_raw, temp_protect_raw, reg_mode_raw};
      misc_sync_reg <= misc_meta_reg;
    end
  end

  // Live status words, available slots forced to zero
  // mapped through S0_MASK and S1_MASK
  assign operation_status_word0 = s0_sync_reg & S0_MASK;
  assign operation_status_word1 = s1_sync_reg & S1_MASK;

  // Questionable word built from the status flags and the synchronised mode, temperature and power loss inputs
  // status subset plus mode, temperature, power loss
  always_comb begin
    q_bits = 16'h0000;
    q_bits[Q_VPROT] = operation_status_word0[S0_TERM_V];
    q_bits[Q_CPROT] = operation_status_word0[S0_TERM_I];
    q_bits[Q_TPROT] = misc_sync_reg[4];
    q_bits[Q_SENSE] = operation_status_word0[S0_SENSE];
    q_bits[Q_CTRIP] = operation_status_word0[S0_CTRIP];
    q_bits[Q_VTRIP] = operation_status_word0[S0_VTRIP];
    q_bits[Q_PTRIP] = operation_status_word0[S0_PTRIP];
    q_bits[Q_MODE_I] = misc_sync_reg[0];
    q_bits[Q_MODE_V] = misc_sync_reg[1];
    q_bits[Q_MODE_R] = misc_sync_reg[2];
    q_bits[Q_CP] = misc_sync_reg[3];
    q_bits[Q_INTLK] = operation_status_word0[S0_INTLK];
    q_bits[Q_PWR_LOSS] = misc_sync_reg[5];
    q_bits[Q_IOF] = operation_status_word0[S0_LINEFLT];
    q_bits[Q_SOFT] = q_bits[Q_CTRIP] | q_bits[Q_VTRIP] | q_bits[Q_PTRIP];
    q_bits[Q_HARD] = q_bits[Q_VPROT] | q_bits[Q_CPROT] | q_bits[Q_TPROT]
      | q_bits[Q_SENSE];
  end

  assign any_soft_fault = q_bits[Q_SOFT];
  assign any_hard_fault = q_bits[Q_HARD];
  assign questionable_fault_word = {16'h0000, q_bits};

  // Input enable object, written only by its index
  // input enable write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= INPUT_EN_RST;
    end else if (req.wr && req.index == IDX_INPUT) begin
      enable_reg <= req.wdata[0];
    end
  end

  assign load_input_enable = enable_reg;
  assign input_high_z = ~enable_reg;

  // Read decode; reads change nothing
  // read without side effect
  always_comb begin
    rdata_next = 64'h0000000000000000;
    err_next = 1'b0;
    if (req.index == IDX_QUES) begin
      rdata_next = {32'h00000000, questionable_fault_word};
      err_next = req.wr;
    end else if (req.index == IDX_STAT) begin
      rdata_next = {operation_status_word1, operation_status_word0};
      err_next = req.wr;
    end else if (req.index == IDX_INPUT) begin
      rdata_next = {63'h0, enable_reg};
    end else begin
      err_next = 1'b1;
    end
  end

  // Registered answer one cycle after request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.rd | req.wr;
      rsp.err <= (req.rd | req.wr) & err_next;
      rsp.rdata <= req.rd ? rdata_next : 64'h0000000000000000;
    end
  end

  // Assertions
  // questionable word live
  property p_ques_live;
    @(posedge clk) disable iff (rst)
    questionable_fault_word[15:0] == q_bits
      && questionable_fault_word[31:16] == 16'h0000;
  endproperty
  a_ques_live: assert property (p_ques_live) else $error("ques");

  property p_ques_read;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_QUES)
      |=> rsp.valid
        && rsp.rdata == {32'h00000000, $past(questionable_fault_word)};
  endproperty
  a_ques_read: assert property (p_ques_read) else $error("ques read");

  property p_read_no_change;
    @(posedge clk) disable iff (rst)
    (req.rd && !req.wr) ##1 ($stable(s0_sync_reg) && $stable(misc_sync_reg))
      |-> $stable(q_bits);
  endproperty
  a_read_no_change: assert property (p_read_no_change)
    else $error("read altered");

  property p_hard_map;
    @(posedge clk) disable iff (rst)
    q_bits[Q_VPROT] == s0_sync_reg[S0_TERM_V]
      && q_bits[Q_CPROT] == s0_sync_reg[S0_TERM_I]
      && q_bits[Q_TPROT] == misc_sync_reg[4]
      && q_bits[Q_SENSE] == s0_sync_reg[S0_SENSE];
  endproperty
  a_hard_map: assert property (p_hard_map) else $error("hard map");

  property p_soft_map;
    @(posedge clk) disable iff (rst)
    q_bits[3:1] == s0_sync_reg[6:4];
  endproperty
  a_soft_map: assert property (p_soft_map) else $error("soft map");

  property p_mode_map;
    @(posedge clk) disable iff (rst)
    !$past(rst, 2) |-> $past(reg_mode_raw, 2) == q_bits[10:7]
      || $changed(misc_sync_reg);
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("mode map");

  property p_soft_or;
    @(posedge clk) disable iff (rst)
    any_soft_fault == (|questionable_fault_word[3:1]);
  endproperty
  a_soft_or: assert property (p_soft_or) else $error("soft or");

  property p_hard_or;
    @(posedge clk) disable iff (rst)
    any_hard_fault
      == (questionable_fault_word[0] | (|questionable_fault_word[6:4]));
  endproperty
  a_hard_or: assert property (p_hard_or) else $error("hard or");

  property p_iface_map;
    @(posedge clk) disable iff (rst)
    q_bits[Q_INTLK] == s0_sync_reg[S0_INTLK]
      && q_bits[Q_PWR_LOSS] == misc_sync_reg[5]
      && q_bits[Q_IOF] == s0_sync_reg[S0_LINEFLT];
  endproperty
  a_iface_map: assert property (p_iface_map) else $error("iface map");

  property p_ques_subset;
    @(posedge clk) disable iff (rst)
    (q_bits[3:1] & ~operation_status_word0[6:4]) == 3'b000
      && (!q_bits[Q_INTLK] || operation_status_word0[S0_INTLK])
      && (!q_bits[Q_IOF] || operation_status_word0[S0_LINEFLT]);
  endproperty
  a_ques_subset: assert property (p_ques_subset)
    else $error("ques subset");

  property p_avail_zero;
    @(posedge clk) disable iff (rst)
    (operation_status_word0 & ~S0_MASK) == 32'h00000000
      && (operation_status_word1 & ~S1_MASK) == 32'h00000000;
  endproperty
  a_avail_zero: assert property (p_avail_zero) else $error("avail");

  property p_stat_read;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.valid
        && rsp.rdata[63:32] == $past(operation_status_word1)
        && rsp.rdata[31:0] == $past(operation_status_word0);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("stat read");

  property p_word0_state;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.rdata[1:0] == $past(s0_sync_reg[1:0]);
  endproperty
  a_word0_state: assert property (p_word0_state)
    else $error("word0 state");

  property p_word0_trip;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.rdata[8:4] == $past(s0_sync_reg[8:4]);
  endproperty
  a_word0_trip: assert property (p_word0_trip)
    else $error("word0 trip");

  property p_word0_term;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.rdata[17:16] == $past(s0_sync_reg[17:16]);
  endproperty
  a_word0_term: assert property (p_word0_term)
    else $error("word0 term");

  property p_word0_heat;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.rdata[S0_LIN_HOT] == $past(s0_sync_reg[S0_LIN_HOT])
        && rsp.rdata[S0_DIODE_HOT] == $past(s0_sync_reg[S0_DIODE_HOT])
        && rsp.rdata[S0_RES_HOT] == $past(s0_sync_reg[S0_RES_HOT]);
  endproperty
  a_word0_heat: assert property (p_word0_heat)
    else $error("word0 heat");

  property p_word0_start;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.rdata[13:12] == $past(s0_sync_reg[13:12]);
  endproperty
  a_word0_start: assert property (p_word0_start)
    else $error("word0 start");

  property p_word0_reg;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.rdata[S0_REG_LOST] == $past(s0_sync_reg[S0_REG_LOST]);
  endproperty
  a_word0_reg: assert property (p_word0_reg)
    else $error("word0 reg");

  property p_word1_flt;
    @(posedge clk) disable iff (rst)
    (req.rd && req.index == IDX_STAT)
      |=> rsp.rdata[34:32] == $past(s1_sync_reg[2:0])
        && rsp.rdata[39:36] == $past(s1_sync_reg[7:4]);
  endproperty
  a_word1_flt: assert property (p_word1_flt)
    else $error("word1 faults");

  property p_enable_write;
    @(posedge clk) disable iff (rst)
    (req.wr && req.index == IDX_INPUT)
      |=> load_input_enable == $past(req.wdata[0])
        && input_high_z == !$past(req.wdata[0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write");

  property p_ro_write;
    @(posedge clk) disable iff (rst)
    (req.wr && (req.index == IDX_QUES || req.index == IDX_STAT))
      |=> rsp.err;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("ro write");

  // Main scenarios reached
  c_ques_read: cover property (@(posedge clk) req.rd && req.index == IDX_QUES);
  c_stat_read: cover property (@(posedge clk) req.rd && req.index == IDX_STAT);
  c_hard: cover property (@(posedge clk) any_hard_fault);
  c_soft: cover property (@(posedge clk) any_soft_fault);
  c_enable: cover property (@(posedge clk) $rose(load_input_enable));

endmodule // lsio_bank

// [dv/lsio_master_model.sv]
// Fieldbus master model issuing single object accesses
module lsio_master_model
  import lsio_pkg::*;
(
  // Clock
  clk,
  // Object bus
  req,
  rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  input wire logic clk;
  output lsio_req_type req;
  input wire lsio_rsp_type rsp;

  // Bus idle at time zero
  initial begin
    req = '0;
  end

  // One request cycle, answer taken one edge later
  task automatic access(input logic rd, input logic wr,
                        input logic [15:0] idx, input logic [31:0] wd,
                        output lsio_rsp_type r);
    @(posedge clk);
    req <= '{rd: rd, wr: wr, index: idx, wdata: wd};
    @(posedge clk);
    req <= '0;
    #1;
    r = rsp;
  endtask

  task automatic set_input(input logic en, output lsio_rsp_type r);
    access(1'b0, 1'b1, IDX_INPUT, {31'h0, en}, r);
  endtask
endmodule // lsio_master_model

// [dv/lsio_bank_tb_top.sv]
// Testbench for the status object bank
module lsio_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lsio_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lsio_req_type req;
  lsio_rsp_type rsp;
  lsio_rsp_type r;
  logic [31:0] s0 = '0;
  logic [31:0] s1 = '0;
  logic [31:0] v;
  logic [3:0] mode = 4'h1;
  logic temp = 1'b0;
  logic input_power_loss = 1'b0;
  logic en;
  logic hz;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  lsio_bank u_dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
    .status0_raw(s0), .status1_raw(s1), .reg_mode_raw(mode),
    .temp_protect_raw(temp), .input_power_loss_raw(input_power_loss),
    .load_input_enable(en), .input_high_z(hz));

  lsio_master_model u_master (.clk(clk), .req(req), .rsp(rsp));

  // Expected questionable word from raw conditions
  function automatic logic [31:0] exp_q(logic [31:0] w, logic [3:0] m,
                                        logic t, logic p);
    logic [31:0] q;
    q = {16'h0, w[26], p, w[20], 2'b00, m, w[7], t, w[16], w[6:4], w[17]};
    q[11] = |q[3:1];
    q[12] = q[0] | q[4] | q[5] | q[6];
    return q;
  endfunction

  // Compare one result
  task automatic chk(input logic [65:0] got, input logic [65:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read, check data, then check the answer pulse has ended
  task automatic rd_chk(input logic [15:0] idx, input logic [63:0] exp);
    u_master.access(1'b1, 1'b0, idx, 32'h0, r);
    chk({r.valid, r.err, r.rdata}, {2'b10, exp});
    @(posedge clk);
    #1;
    chk({65'h0, rsp.valid}, 66'h0);
  endtask

  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  // Test sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({64'h0, en, hz}, {64'h0, 2'b01});
    rd_chk(IDX_INPUT, 64'h0);
    $display("test reset done");
    for (int i = 0; i < 33; i++) begin
      v = (i < 32) ? (32'h1 << i) : 32'hFFFFFFFF;
      @(posedge clk);
      s0 <= v;
      s1 <= v;
      mode <= 4'h1 << (i % 4);
      temp <= (i == 5) || (i == 32);
      input_power_loss <= (i == 14) || (i == 32);
      repeat (3) @(posedge clk);
      rd_chk(IDX_QUES, {32'h0, exp_q(s0, mode, temp, input_power_loss)});
      rd_chk(IDX_QUES, {32'h0, exp_q(s0, mode, temp, input_power_loss)});
      rd_chk(IDX_STAT, {s1 & S1_MASK, s0 & S0_MASK});
    end
    $display("test status walk done");
    u_master.access(1'b0, 1'b1, IDX_QUES, 32'hFFFFFFFF, r);
    chk({r.valid, r.err, r.rdata}, {2'b11, 64'h0});
    u_master.access(1'b0, 1'b1, IDX_STAT, 32'hFFFFFFFF, r);
    chk({r.valid, r.err, r.rdata}, {2'b11, 64'h0});
    rd_chk(IDX_STAT, {32'h000300F7, 32'h7FDFFFF3});
    u_master.access(1'b1, 1'b0, 16'h2012, 32'h0, r);
    chk({r.valid, r.err, r.rdata}, {2'b11, 64'h0});
    u_master.set_input(1'b1, r);
    chk({r.valid, r.err, r.rdata}, {2'b10, 64'h0});
    chk({64'h0, en, hz}, {64'h0, 2'b10});
    rd_chk(IDX_INPUT, 64'h1);
    u_master.set_input(1'b0, r);
    chk({64'h0, en, hz}, {64'h0, 2'b01});
    $display("test access done");
    end_sim();
  end
endmodule // lsio_bank_tb_top
